// file: include/dsrpd_regs.vh
`ifndef DSRPD_REGS_VH
`define DSRPD_REGS_VH
// clock period in ps (mclk, 20 MHz)
`define DSRPD_TCK_PS 50000
// timing figures in ps and the derived cycle counts (mins round up)
`define DSRPD_TCKE_PS 5000
`define DSRPD_TCKE_CYC ((`DSRPD_TCKE_PS + `DSRPD_TCK_PS - 1) / `DSRPD_TCK_PS)
`define DSRPD_TCPDED_CYC 1
`define DSRPD_TXP_PS 6000
`define DSRPD_TXP_CYC ((`DSRPD_TXP_PS + `DSRPD_TCK_PS - 1) / `DSRPD_TCK_PS)
`define DSRPD_TXPDLL_PS 24000
`define DSRPD_TXPDLL_CYC ((`DSRPD_TXPDLL_PS + `DSRPD_TCK_PS - 1) / `DSRPD_TCK_PS)
`define DSRPD_TXS_PS 170000
`define DSRPD_TXS_CYC ((`DSRPD_TXS_PS + `DSRPD_TCK_PS - 1) / `DSRPD_TCK_PS)
`define DSRPD_TXSDLL_CYC 512
// internal self-refresh timer reload value in mclk cycles (period is one more)
`define DSRPD_SR_TIMER 16'h0100
// counter width
`define DSRPD_CW 16
// state codes, one-hot
`define DSRPD_ST_W 6
`define DSRPD_ST_IDLE 6'h01
`define DSRPD_ST_SREF 6'h02
`define DSRPD_ST_SRX 6'h04
`define DSRPD_ST_PPD 6'h08
`define DSRPD_ST_APD 6'h10
`define DSRPD_ST_PDX 6'h20
`endif

// file: design/dsrpd_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "dsrpd_regs.vh"
// loadable down counter; done is high while the count is zero
module dsrpd_counter (
   // clock and reset
   input wire mclk,
   input wire rst,
   // control
   input wire load,
   input wire [`DSRPD_CW-1:0] value,
   // status
   output reg done
);
   reg [`DSRPD_CW-1:0] count;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         count <= 16'h0000;
         done <= 1'b1;
      end else if (load) begin
         count <= value;
         done <= (value == 16'h0000);
      end else if (count != 16'h0000) begin
         count <= count - 16'h0001;
         done <= (count == 16'h0001);
      end
   end
endmodule
`default_nettype wire

// file: design/dsrpd_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "dsrpd_regs.vh"
// Contract
// - sre decoded: cs ras cas cke low, we high
// - cke low holds sref; other inputs except reset ignored
// - dll off in sref, reset on exit; dll_reset is only raised on exit with dll_off_mode low
// - refresh within tcke, then own timer
// - power-down entry/exit: cke with nop
// - closed banks precharge pd, else active pd
// - nop around cke fall; receivers off after tcpded
// - slow exit dll off txpdll; fast txp
// - reset low in pd enters reset state
module dsrpd_ctrl (
   // clock and reset
   input wire mclk,
   input wire rst,
   // memory pins
   input wire cke,
   input wire cs_n,
   input wire ras_n,
   input wire cas_n,
   input wire we_n,
   input wire reset_n,
   // mode bits and core status
   input wire dll_off_mode,
   input wire pd_fast_exit,
   input wire any_bank_open,
   // status out
   output reg [`DSRPD_ST_W-1:0] state,
   output reg dll_enable,
   output reg dll_reset,
   output reg rcv_enable,
   output reg refresh_req,
   output reg in_reset,
   output reg dll_cmds_ok,
   output reg cmds_ok,
   output reg write_ok
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg [5:0] pin_s1;
   reg [5:0] pin_s2;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_s1 <= 6'h3f;
         pin_s2 <= 6'h3f;
      end else begin
         pin_s1 <= {cke, cs_n, ras_n, cas_n, we_n, reset_n};
         pin_s2 <= pin_s1;
      end
   end
   wire cke_q = pin_s2[5];
   wire rst_pin_n = pin_s2[0];
   reg cke_prev;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         cke_prev <= 1'b1;
      end else begin
         cke_prev <= cke_q;
      end
   end
   // nop or deselect
   wire is_nop = pin_s2[4] | (pin_s2[3] & pin_s2[2] & pin_s2[1]);
   wire is_sre = cke_prev & ~cke_q & ~pin_s2[4] & ~pin_s2[3] & ~pin_s2[2] & pin_s2[1];
   wire cke_fall = cke_prev & ~cke_q & is_nop;
   wire cke_rise = ~cke_prev & cke_q & is_nop;
   // ----------------------------------------
   // interval counters
   // ----------------------------------------
   reg ld_cke, ld_x, ld_xdll, ld_wr, ld_sr, ld_cp;
   reg [`DSRPD_CW-1:0] v_x;
   reg [`DSRPD_CW-1:0] v_xdll;
   wire dn_cke, dn_x, dn_xdll, dn_wr, dn_sr, dn_cp;
   // counts are integer-wide; only the counter width is kept
   wire [31:0] cyc_tcke = `DSRPD_TCKE_CYC;
   wire [31:0] cyc_tcpded = `DSRPD_TCPDED_CYC;
   wire [31:0] cyc_txp = `DSRPD_TXP_CYC;
   wire [31:0] cyc_txpdll = `DSRPD_TXPDLL_CYC;
   wire [31:0] cyc_txs = `DSRPD_TXS_CYC;
   wire [31:0] cyc_txsdll = `DSRPD_TXSDLL_CYC;
   dsrpd_counter u_cke (.mclk(mclk), .rst(rst), .load(ld_cke),
      .value(cyc_tcke[`DSRPD_CW-1:0]), .done(dn_cke));
   dsrpd_counter u_x (.mclk(mclk), .rst(rst), .load(ld_x), .value(v_x), .done(dn_x));
   dsrpd_counter u_xdll (.mclk(mclk), .rst(rst), .load(ld_xdll), .value(v_xdll),
      .done(dn_xdll));
   dsrpd_counter u_wr (.mclk(mclk), .rst(rst), .load(ld_wr),
      .value(cyc_txsdll[`DSRPD_CW-1:0]), .done(dn_wr));
   dsrpd_counter u_sr (.mclk(mclk), .rst(rst), .load(ld_sr),
      .value(`DSRPD_SR_TIMER), .done(dn_sr));
   dsrpd_counter u_cp (.mclk(mclk), .rst(rst), .load(ld_cp),
      .value(cyc_tcpded[`DSRPD_CW-1:0]), .done(dn_cp));
   // ----------------------------------------
   // state machine
   // ----------------------------------------
   reg [`DSRPD_ST_W-1:0] next_state;
   reg slow_pd;
   reg next_slow_pd;
   always @* begin
      next_state = state;
      next_slow_pd = slow_pd;
      ld_cke = 1'b0;
      ld_x = 1'b0;
      ld_xdll = 1'b0;
      ld_wr = 1'b0;
      ld_sr = 1'b0;
      ld_cp = 1'b0;
      v_x = cyc_txs[`DSRPD_CW-1:0];
      v_xdll = cyc_txsdll[`DSRPD_CW-1:0];
      case (state)
         `DSRPD_ST_IDLE, `DSRPD_ST_SRX, `DSRPD_ST_PDX: begin
            if (is_sre) begin
               next_state = `DSRPD_ST_SREF;
               ld_sr = 1'b1;
               ld_cke = 1'b1;
            end else if (cke_fall) begin
               next_state = any_bank_open ? `DSRPD_ST_APD : `DSRPD_ST_PPD;
               next_slow_pd = ~any_bank_open & ~pd_fast_exit;
               ld_cke = 1'b1;
               ld_cp = 1'b1;
            end else if ((state != `DSRPD_ST_IDLE) & dn_x & dn_xdll) begin
               next_state = `DSRPD_ST_IDLE;
            end
         end
         `DSRPD_ST_SREF: begin
            if (dn_sr) begin
               ld_sr = 1'b1;
            end
            if (cke_q & ~cke_prev) begin
               next_state = `DSRPD_ST_SRX;
               ld_x = 1'b1;
               ld_xdll = 1'b1;
               ld_wr = 1'b1;
            end
         end
         `DSRPD_ST_PPD, `DSRPD_ST_APD: begin
            // a rise before tcke has run out is not taken as an exit
            if (cke_rise & dn_cke) begin
               next_state = `DSRPD_ST_PDX;
               ld_cke = 1'b1;
               v_x = cyc_txp[`DSRPD_CW-1:0];
               v_xdll = slow_pd ? cyc_txpdll[`DSRPD_CW-1:0] : cyc_txp[`DSRPD_CW-1:0];
               ld_x = 1'b1;
               ld_xdll = 1'b1;
            end
         end
         default: begin
            next_state = `DSRPD_ST_IDLE;
         end
      endcase
   end
   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   wire in_pd = (state == `DSRPD_ST_PPD) | (state == `DSRPD_ST_APD);
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= `DSRPD_ST_IDLE;
         slow_pd <= 1'b0;
         dll_enable <= 1'b0;
         dll_reset <= 1'b0;
         rcv_enable <= 1'b1;
         refresh_req <= 1'b0;
         in_reset <= 1'b1;
         dll_cmds_ok <= 1'b0;
         cmds_ok <= 1'b0;
         write_ok <= 1'b0;
      end else if (~rst_pin_n) begin
         // reset pin overrides any power-down or self-refresh
         state <= `DSRPD_ST_IDLE;
         slow_pd <= 1'b0;
         dll_enable <= 1'b0;
         dll_reset <= 1'b0;
         rcv_enable <= 1'b1;
         refresh_req <= 1'b0;
         in_reset <= 1'b1;
         dll_cmds_ok <= 1'b0;
         cmds_ok <= 1'b0;
         write_ok <= 1'b0;
      end else begin
         state <= next_state;
         slow_pd <= next_slow_pd;
         in_reset <= 1'b0;
         if (next_state == `DSRPD_ST_SREF) begin
            dll_enable <= 1'b0;
         end else if (in_pd & slow_pd) begin
            dll_enable <= (next_state != `DSRPD_ST_PPD) & ~dll_off_mode;
         end else if (next_state == `DSRPD_ST_PPD) begin
            dll_enable <= ~next_slow_pd & ~dll_off_mode;
         end else begin
            dll_enable <= ~dll_off_mode;
         end
         dll_reset <= (state == `DSRPD_ST_SREF) & (next_state == `DSRPD_ST_SRX) & ~dll_off_mode;
         // receivers drop only after tcpded in power-down, and in self-refresh
         rcv_enable <= ~((in_pd & dn_cp & ~ld_cp) | (state == `DSRPD_ST_SREF));
         // first internal refresh at entry, then on the own timer
         refresh_req <= ((state != `DSRPD_ST_SREF) & (next_state == `DSRPD_ST_SREF)) |
            ((state == `DSRPD_ST_SREF) & dn_sr);
         cmds_ok <= (next_state == `DSRPD_ST_IDLE) |
            (((state == `DSRPD_ST_SRX) | (state == `DSRPD_ST_PDX)) & dn_x & ~ld_x);
         dll_cmds_ok <= (next_state == `DSRPD_ST_IDLE) & ~ld_xdll;
         write_ok <= (next_state == `DSRPD_ST_IDLE) & dn_wr & ~ld_wr;
      end
   end
endmodule
`default_nettype wire

// file: verif/dsrpd_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsrpd_regs.vh"
module dsrpd_ctrl_asserts (
   // clock, reset and pins
   input wire logic mclk, rst, cke, cs_n, ras_n, cas_n, we_n, reset_n,
   // mode bits and status
   input wire logic dll_off_mode, pd_fast_exit, any_bank_open,
   input wire logic [`DSRPD_ST_W-1:0] state,
   input wire logic dll_enable, dll_reset, rcv_enable, refresh_req,
   input wire logic in_reset, dll_cmds_ok, cmds_ok, write_ok
);
   // ---------------------------------------------
   // properties, pins seen three edges ahead
   // ---------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire nop = cs_n | (ras_n & cas_n & we_n);
   wire idle = state == `DSRPD_ST_IDLE;
   wire sref = state == `DSRPD_ST_SREF;
   wire srx = state == `DSRPD_ST_SRX;
   wire pd = state == `DSRPD_ST_PPD || state == `DSRPD_ST_APD;
   chk_sre_taken: assert property (idle && $fell(cke) && !cs_n && !ras_n && !cas_n && we_n
      && reset_n |-> ##3 sref) else $error("self-refresh entry missed");
   chk_sref_entry: assert property ($rose(sref) |-> refresh_req && !dll_enable ##1 !rcv_enable)
      else $error("self-refresh entry outputs wrong");
   chk_sref_hold: assert property ((sref && !cke && reset_n)[*3] |=> sref)
      else $error("self-refresh left with cke low");
   chk_srx_taken: assert property (sref && !cke && reset_n ##1 cke && reset_n |-> ##3 srx
      && dll_reset == !dll_off_mode) else $error("self-refresh exit wrong");
   chk_sref_timer: assert property (refresh_req && sref |-> ##257 refresh_req || !sref)
      else $error("internal refresh late");
   chk_srx_gates: assert property ($rose(srx) |-> !cmds_ok && !write_ok ##[2:6] cmds_ok)
      else $error("exit command gate wrong");
   chk_write_gate: assert property ($rose(srx) |-> ##[505:525] write_ok)
      else $error("write gate not opened");
   chk_pd_kind: assert property (idle && $fell(cke) && nop && reset_n |-> ##3
      state == (any_bank_open ? `DSRPD_ST_APD : `DSRPD_ST_PPD))
      else $error("power-down kind wrong");
   chk_pd_rcv_off: assert property (pd[*3] |-> !rcv_enable)
      else $error("receivers on in power-down");
   chk_pd_reset: assert property (pd && !reset_n |-> ##[1:3] in_reset && idle)
      else $error("reset pin ignored in power-down");
   cover property ($rose(sref));
   cover property ($rose(state == `DSRPD_ST_APD));
   cover property ($rose(state == `DSRPD_ST_PPD));
endmodule
bind dsrpd_ctrl dsrpd_ctrl_asserts dsrpd_ctrl_asserts_inst (.mclk(mclk), .rst(rst), .cke(cke),
   .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .reset_n(reset_n),
   .dll_off_mode(dll_off_mode), .pd_fast_exit(pd_fast_exit), .any_bank_open(any_bank_open),
   .state(state), .dll_enable(dll_enable), .dll_reset(dll_reset), .rcv_enable(rcv_enable),
   .refresh_req(refresh_req), .in_reset(in_reset), .dll_cmds_ok(dll_cmds_ok),
   .cmds_ok(cmds_ok), .write_ok(write_ok));
`default_nettype wire

// file: verif/dsrpd_mc_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsrpd_mc_model (
   // clock
   input wire logic mclk,
   // pins toward the device
   output logic cke, cs_n, ras_n, cas_n, we_n, reset_n
);
   // ---------------------------------------------
   // one command per falling edge
   // ---------------------------------------------
   initial begin
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      reset_n = 1'b1;
   end
   // clock never stops, so no restart interval is needed
   task step(input logic k, input logic [3:0] c);
      begin
         @(negedge mclk);
         cke = k;
         // deselected pins toggle so a stale level cannot pass as a command
         if (c[3]) {ras_n, cas_n, we_n} = ~{ras_n, cas_n, we_n};
         else {ras_n, cas_n, we_n} = c[2:0];
         cs_n = c[3];
      end
   endtask
   task pin_reset(input logic v);
      begin
         @(negedge mclk);
         reset_n = v;
      end
   endtask
endmodule
`default_nettype wire

// file: verif/dsrpd_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsrpd_regs.vh"
module dsrpd_ctrl_tb_top;
   localparam [3:0] NOP = 4'h7, DES = 4'hf, REF = 4'h1;
   logic mclk, rst, dll_off_mode, pd_fast_exit, any_bank_open;
   wire cke, cs_n, ras_n, cas_n, we_n, reset_n;
   wire [`DSRPD_ST_W-1:0] state;
   wire dll_enable, dll_reset, rcv_enable, refresh_req, in_reset, dll_cmds_ok, cmds_ok, write_ok;
   integer seed = 32'hc90925fa;
   integer err_total = 0, tests_run = 0, i, n, b;
   dsrpd_mc_model dsrpd_mc_model_inst (.mclk(mclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .reset_n(reset_n));
   dsrpd_ctrl dsrpd_ctrl_inst (.mclk(mclk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .reset_n(reset_n), .dll_off_mode(dll_off_mode),
      .pd_fast_exit(pd_fast_exit), .any_bank_open(any_bank_open), .state(state),
      .dll_enable(dll_enable), .dll_reset(dll_reset), .rcv_enable(rcv_enable),
      .refresh_req(refresh_req), .in_reset(in_reset), .dll_cmds_ok(dll_cmds_ok),
      .cmds_ok(cmds_ok), .write_ok(write_ok));
   // ---------------------------------------------
   // clock, checks and bounded waits
   // ---------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   function [5:0] exp_pd(input logic open);
      exp_pd = open ? `DSRPD_ST_APD : `DSRPD_ST_PPD;
   endfunction
   function [3:0] rnd_cmd();
      integer r;
      begin
         r = $random(seed);
         rnd_cmd = r[3:0];
      end
   endfunction
   task check(input logic [7:0] got, input logic [7:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_total = err_total + 1;
         end
      end
   endtask
   task stop_test;
      begin
         if (err_total == 0 && tests_run > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task wait_idle;
      begin
         for (n = 0; n < 700 && state !== `DSRPD_ST_IDLE; n = n + 1)
            dsrpd_mc_model_inst.step(1'b1, NOP);
         if (n == 700) begin
            err_total = err_total + 1;
            stop_test;
         end
      end
   endtask
   initial begin
      rst = 1'b1;
      dll_off_mode = 1'b0;
      pd_fast_exit = 1'b0;
      any_bank_open = 1'b0;
      repeat (16) @(negedge mclk);
      check({state, in_reset, rcv_enable}, {`DSRPD_ST_IDLE, 2'b11});
      rst = 1'b0;
      repeat (3) dsrpd_mc_model_inst.step(1'b1, NOP);
      // self-refresh with both dll modes; commands during residency must be ignored
      for (i = 0; i < 2; i = i + 1) begin
         dll_off_mode = i[0];
         dsrpd_mc_model_inst.step(1'b1, REF);
         repeat (8) dsrpd_mc_model_inst.step(1'b1, NOP);
         dsrpd_mc_model_inst.step(1'b0, REF);
         repeat (3) dsrpd_mc_model_inst.step(1'b0, DES);
         check({state, refresh_req, dll_enable}, {`DSRPD_ST_SREF, 2'b10});
         n = 260 + ($random(seed) & 63);
         repeat (n) dsrpd_mc_model_inst.step(1'b0, rnd_cmd());
         repeat (4) dsrpd_mc_model_inst.step(1'b1, DES);
         check({state, dll_reset, cmds_ok}, {`DSRPD_ST_SRX, ~dll_off_mode, 1'b0});
         check({7'h00, dll_cmds_ok}, 8'h00);
         for (n = 3; n < 700 && write_ok !== 1'b1; n = n + 1)
            dsrpd_mc_model_inst.step(1'b1, NOP);
         check({7'h0, n >= 505 && n <= 530}, 8'h01);
         check({6'h00, dll_cmds_ok, cmds_ok}, 8'h03);
         wait_idle;
      end
      // power-down: every bank and exit combination, then random ones
      dll_off_mode = 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         b = (i < 4) ? i : $random(seed);
         any_bank_open = b[0];
         pd_fast_exit = b[1];
         dsrpd_mc_model_inst.step(1'b0, NOP);
         repeat (5) dsrpd_mc_model_inst.step(1'b0, DES);
         check({state, rcv_enable, dll_enable}, {exp_pd(b[0]), 1'b0, b[0] | b[1]});
         repeat (4) dsrpd_mc_model_inst.step(1'b0, rnd_cmd());
         if (i == 7) begin
            dsrpd_mc_model_inst.pin_reset(1'b0);
            repeat (3) dsrpd_mc_model_inst.step(1'b0, NOP);
            check({state, in_reset, 1'b0}, {`DSRPD_ST_IDLE, 2'b10});
            dsrpd_mc_model_inst.pin_reset(1'b1);
         end else begin
            repeat (4) dsrpd_mc_model_inst.step(1'b1, NOP);
            check({7'h0, state !== exp_pd(b[0])}, 8'h01);
         end
         wait_idle;
      end
      stop_test;
   end
endmodule
`default_nettype wire
